// ==== core/pgnf_pkg.sv ====
package pgnf_pkg;
  localparam int ADDR_W = 4; // register address width
  localparam int DATA_W = 8; // register data width
  localparam int NPINS  = 8; // pins in the port
  // register offsets
  localparam logic [3:0] OFS_DIR_PIN = 4'h0; // direction write, pin state read
  localparam logic [3:0] OFS_OUTDATA = 4'h1; // output data
  localparam logic [3:0] OFS_NCE     = 4'h2; // filter enable bits
  localparam logic [3:0] OFS_NCMC    = 4'h3; // filter expected level bits
  localparam logic [3:0] OFS_PERIOD  = 4'h4; // filter_sample_period
  localparam logic [3:0] OFS_ROUTE   = 4'h5; // port_route_control
  localparam logic [3:0] OFS_I2C2    = 4'h6; // i2c2_control_reg
  // reset values
  localparam logic [7:0] RST_BYTE    = 8'h00; // all control regs reset zero
  localparam logic [2:0] RST_PERIOD  = 3'h0; // period field reset
  localparam logic [7:0] UNMAPPED_RD = 8'h00; // unmapped read answer
  // field positions
  localparam int PERIOD_LSB = 0; // period code low bit
  localparam int PERIOD_MSB = 2; // period code high bit
  localparam int BIT_CH1_BUSB = 3; // route bits in port_route_control
  localparam int BIT_CH0_BUSB = 2;
  localparam int BIT_CH1_BUSA = 1;
  localparam int BIT_CH0_BUSA = 0;
  localparam int BIT_I2C2_EN  = 7; // interface enable in i2c2_control_reg
  // pin indices
  localparam int PIN_BUSB_CLK = 7;
  localparam int PIN_BUSB_DAT = 6;
  localparam int PIN_BUSA_CLK = 5;
  localparam int PIN_BUSA_DAT = 4;
  localparam int PIN_CH2_CLK  = 3;
  localparam int PIN_CH2_DAT  = 2;
  localparam int PIN_TIMER_Y  = 1;
  localparam int PIN_TIMER_X  = 0;
  // timer control fields
  localparam logic [2:0] CKS_EXT_LO = 3'h5; // lowest external clock code
  // divide exponents per period code
  localparam int DIV_EXP0 = 1;  // divide by 2
  localparam int DIV_EXP1 = 5;  // divide by 32
  localparam int DIV_EXP2 = 13; // divide by 8192, doubles per step
  localparam int DIV_W    = 18; // up to 262144
  localparam int SYNC_STAGES = 3; // pin synchronizer depth
endpackage

// ==== core/pgnf_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgnf_tick_gen #(
  parameter int DIV_W = pgnf_pkg::DIV_W // divider width
) (
  input  wire logic       clk,     // system clock
  input  wire logic       sys_rst, // sync reset, active high
  input  wire logic [2:0] period,  // sample period code
  output logic            tick     // one-cycle sample pulse
);
  logic [DIV_W-1:0] count;       // free-running divider
  logic [2:0]       period_q;    // last code, to spot changes
  logic [DIV_W-1:0] next_count;  // divider next value
  logic [DIV_W-1:0] terminal;    // last count of the period
  logic             changed;     // code differs from last cycle

  // divide ratio from the code, minus one
  function automatic logic [DIV_W-1:0] last_count(input logic [2:0] code);
    int exp_v;
    exp_v = (code == 3'h0) ? pgnf_pkg::DIV_EXP0 :
            (code == 3'h1) ? pgnf_pkg::DIV_EXP1 :
            pgnf_pkg::DIV_EXP2 + int'(code) - 2;
    return DIV_W'((DIV_W+1)'(1) << exp_v) - DIV_W'(1);
  endfunction

  assign terminal   = last_count(period);
  assign changed    = (period != period_q);
  // restart from zero on a code change so a stale count never misfires
  assign next_count = (changed || count >= terminal) ? '0 : count + DIV_W'(1);
  assign tick       = !changed && (count == terminal);

  // divider state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count    <= '0;
      period_q <= pgnf_pkg::RST_PERIOD;
    end else begin
      count    <= next_count;
      period_q <= period;
    end
  end
endmodule
`default_nettype wire

// ==== core/pgnf_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgnf_filter #(
  parameter int NPINS = pgnf_pkg::NPINS // pins filtered
) (
  input  wire logic             clk,      // system clock
  input  wire logic             sys_rst,  // sync reset, active high
  input  wire logic             tick,     // sample pulse
  input  wire logic [NPINS-1:0] level,    // synchronized pin level
  input  wire logic [NPINS-1:0] enable,   // filter_enable_bits
  input  wire logic [NPINS-1:0] expect_hi,// filter_expected_level_bits
  output logic      [NPINS-1:0] state     // pin state value
);
  logic [NPINS-1:0] last_smp;   // previous sample
  logic [NPINS-1:0] stable_exp; // two samples equal expected level
  logic [NPINS-1:0] take_exp;   // tick with a stable expected level
  logic [NPINS-1:0] next_state; // per-pin next state

  assign stable_exp = ~(level ^ expect_hi) & ~(last_smp ^ expect_hi);
  assign take_exp   = tick ? stable_exp : '0;
  // unfiltered pins follow the pin; filtered ones move only on a stable
  // expected level, otherwise they hold, which masks glitches of the other sense
  assign next_state = (~enable & level)
                    | (enable & take_exp & expect_hi)
                    | (enable & ~take_exp & state);

  // sample history and state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_smp <= '0;
      state    <= '0;
    end else begin
      if (tick) begin
        last_smp <= level;
      end
      state <= next_state;
    end
  end
endmodule
`default_nettype wire

// ==== core/pgnf_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module pgnf_port #(
  parameter int NPINS = pgnf_pkg::NPINS // pins in the port
) (
  input  wire logic                        clk,         // system clock
  input  wire logic                        sys_rst,     // sync reset, active high
  // register port
  input  wire logic [pgnf_pkg::ADDR_W-1:0] reg_addr,    // register address
  input  wire logic [pgnf_pkg::DATA_W-1:0] reg_wdata,   // write data
  input  wire logic                        reg_wr,      // write strobe
  input  wire logic                        reg_rd,      // read strobe
  output logic      [pgnf_pkg::DATA_W-1:0] reg_rdata,   // read data, next cycle
  // pins
  input  wire logic [NPINS-1:0]            pin_in,      // pin levels
  output logic      [NPINS-1:0]            pin_out,     // pin drive value
  output logic      [NPINS-1:0]            pin_oe,      // pin drive enable
  // i2c units
  input  wire logic                        busa_clock_drv_low, // bus-A clock pull low
  input  wire logic                        busa_data_drv_low,  // bus-A data pull low
  input  wire logic                        busb_clock_drv_low, // bus-B clock pull low
  input  wire logic                        busb_data_drv_low,  // bus-B data pull low
  input  wire logic                        chan2_clock_drv_low,// ch2 clock pull low
  input  wire logic                        chan2_data_drv_low, // ch2 data pull low
  output logic                             busa_clock_line,    // bus-A clock level
  output logic                             busa_data_line,     // bus-A data level
  output logic                             busb_clock_line,    // bus-B clock level
  output logic                             busb_data_line,     // bus-B data level
  output logic                             chan2_clock_line,   // ch2 clock level
  output logic                             chan2_data_line,    // ch2 data level
  // interrupt controller
  input  wire logic [NPINS-1:0]            irq_source_sel,     // source select 15..8
  input  wire logic [NPINS-1:0]            irq_enable,         // enable 15..8
  output logic      [NPINS-1:0]            ext_interrupt,      // ext interrupts 15..8
  // timers
  input  wire logic [1:0]                  timer_x_clear_sel,  // clear select hi,lo
  input  wire logic [2:0]                  timer_x_clock_sel,  // clock select code
  input  wire logic [1:0]                  timer_y_clear_sel,  // clear select hi,lo
  input  wire logic [2:0]                  timer_y_clock_sel,  // clock select code
  output logic                             timer_x_clear_in,   // timer X clear input
  output logic                             timer_x_clock_in,   // timer X clock input
  output logic                             timer_y_clear_in,   // timer Y clear input
  output logic                             timer_y_clock_in    // timer Y clock input
);
  // control registers
  logic [NPINS-1:0] direction_reg;        // 1 = output
  logic [NPINS-1:0] out_data;             // general output data
  logic [NPINS-1:0] filter_enable_bits;   // filter on per pin
  logic [NPINS-1:0] filter_expected_level_bits; // expected level per pin
  logic [2:0]       sample_period_sel;    // period code
  logic [3:0]       port_route_control;   // I2C routing bits
  logic             i2c2_interface_enable;// ch2 pin takeover
  // pin synchronizer, three stages
  logic [NPINS-1:0] sync1;                // first stage, read only by sync2
  logic [NPINS-1:0] sync2;                // second stage
  logic [NPINS-1:0] sync3;                // third stage
  logic [NPINS-1:0] level;                // agreed synchronized level
  logic [NPINS-1:0] pin_state_reg;        // filtered pin state
  logic             tick;                 // sample pulse
  // decode
  logic             hit_dir, hit_out, hit_nce, hit_ncmc, hit_per, hit_route, hit_i2c2;
  logic             busb_on, busa_on;     // bus pair routed
  logic [NPINS-1:0] i2c_mode;             // pin is an I2C line
  logic [NPINS-1:0] i2c_low;              // I2C unit pulls the line low
  logic [pgnf_pkg::DATA_W-1:0] rd_mux;    // read selection
  logic             x_ext, y_ext;         // timers on external clock

  assign hit_dir   = reg_addr == pgnf_pkg::OFS_DIR_PIN;
  assign hit_out   = reg_addr == pgnf_pkg::OFS_OUTDATA;
  assign hit_nce   = reg_addr == pgnf_pkg::OFS_NCE;
  assign hit_ncmc  = reg_addr == pgnf_pkg::OFS_NCMC;
  assign hit_per   = reg_addr == pgnf_pkg::OFS_PERIOD;
  assign hit_route = reg_addr == pgnf_pkg::OFS_ROUTE;
  assign hit_i2c2  = reg_addr == pgnf_pkg::OFS_I2C2;

  // register writes; reserved period bits are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direction_reg              <= pgnf_pkg::RST_BYTE;
      out_data                   <= pgnf_pkg::RST_BYTE;
      filter_enable_bits         <= pgnf_pkg::RST_BYTE;
      filter_expected_level_bits <= pgnf_pkg::RST_BYTE;
      sample_period_sel          <= pgnf_pkg::RST_PERIOD;
      port_route_control         <= '0;
      i2c2_interface_enable      <= 1'b0;
    end else if (reg_wr) begin
      if (hit_dir)   direction_reg              <= reg_wdata;
      if (hit_out)   out_data                   <= reg_wdata;
      if (hit_nce)   filter_enable_bits         <= reg_wdata;
      if (hit_ncmc)  filter_expected_level_bits <= reg_wdata;
      if (hit_per)   sample_period_sel <= reg_wdata[pgnf_pkg::PERIOD_MSB:pgnf_pkg::PERIOD_LSB];
      if (hit_route) port_route_control         <= reg_wdata[3:0];
      if (hit_i2c2)  i2c2_interface_enable      <= reg_wdata[pgnf_pkg::BIT_I2C2_EN];
    end
  end

  // read mux; reserved bits read zero
  assign rd_mux = hit_dir   ? pin_state_reg :
                  hit_out   ? out_data :
                  hit_nce   ? filter_enable_bits :
                  hit_ncmc  ? filter_expected_level_bits :
                  hit_per   ? {5'h00, sample_period_sel} :
                  hit_route ? {4'h0, port_route_control} :
                  hit_i2c2  ? {i2c2_interface_enable, 7'h00} :
                  pgnf_pkg::UNMAPPED_RD;

  // read data registered, valid only the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // pin synchronizer; a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (sync2 & sync3) | (level & (sync2 ^ sync3));
    end
  end

  pgnf_tick_gen #(.DIV_W(pgnf_pkg::DIV_W)) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .period  (sample_period_sel),
    .tick    (tick)
  );

  pgnf_filter #(.NPINS(NPINS)) u_filt (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .tick      (tick),
    .level     (level),
    .enable    (filter_enable_bits),
    .expect_hi (filter_expected_level_bits),
    .state     (pin_state_reg)
  );

  // pin function selection
  assign busb_on = port_route_control[pgnf_pkg::BIT_CH1_BUSB]
                 | port_route_control[pgnf_pkg::BIT_CH0_BUSB];
  assign busa_on = port_route_control[pgnf_pkg::BIT_CH1_BUSA]
                 | port_route_control[pgnf_pkg::BIT_CH0_BUSA];
  assign i2c_mode = {busb_on, busb_on, busa_on, busa_on,
                     i2c2_interface_enable, i2c2_interface_enable, 2'b00};
  assign i2c_low  = {busb_clock_drv_low, busb_data_drv_low,
                     busa_clock_drv_low, busa_data_drv_low,
                     chan2_clock_drv_low, chan2_data_drv_low, 2'b00};

  // I2C lines only sink current; general outputs drive both levels
  assign pin_out = i2c_mode & '0 | ~i2c_mode & out_data;
  assign pin_oe  = (i2c_mode & i2c_low)
                 | (~i2c_mode & direction_reg);

  // I2C units see the synchronized line level
  assign busb_clock_line  = level[pgnf_pkg::PIN_BUSB_CLK] | ~busb_on;
  assign busb_data_line   = level[pgnf_pkg::PIN_BUSB_DAT] | ~busb_on;
  assign busa_clock_line  = level[pgnf_pkg::PIN_BUSA_CLK] | ~busa_on;
  assign busa_data_line   = level[pgnf_pkg::PIN_BUSA_DAT] | ~busa_on;
  assign chan2_clock_line = level[pgnf_pkg::PIN_CH2_CLK] | ~i2c2_interface_enable;
  assign chan2_data_line  = level[pgnf_pkg::PIN_CH2_DAT] | ~i2c2_interface_enable;

  // interrupts pass only when both controller bits are set; idle high
  assign ext_interrupt = (level | ~(irq_source_sel & irq_enable));

  assign x_ext = timer_x_clock_sel >= pgnf_pkg::CKS_EXT_LO;
  assign y_ext = timer_y_clock_sel >= pgnf_pkg::CKS_EXT_LO;
  // timer inputs from the synchronized pin, low when not selected
  assign timer_y_clear_in = &timer_y_clear_sel & level[pgnf_pkg::PIN_TIMER_Y];
  assign timer_y_clock_in = y_ext & level[pgnf_pkg::PIN_TIMER_Y];
  assign timer_x_clear_in = &timer_x_clear_sel & level[pgnf_pkg::PIN_TIMER_X];
  assign timer_x_clock_in = x_ext & level[pgnf_pkg::PIN_TIMER_X];
endmodule
`default_nettype wire

// ==== verif/pgnf_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// board side of the eight pins: outside driver plus a pull-up on every line
module pgnf_pin_model (
  input  wire logic [7:0] pin_out, // device drive value
  input  wire logic [7:0] pin_oe,  // device drive enable
  input  wire logic [7:0] ext_val, // outside driver level
  input  wire logic [7:0] ext_drv, // outside driver enable
  output logic      [7:0] pin_in   // resolved pin level
);
  // released lines float up, so a stale value can never pass as a drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_drv)
                | (~pin_oe & ext_drv & ext_val);
endmodule
`default_nettype wire

// ==== verif/pgnf_port_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// passive watcher on the port's pins, routing and alternate outputs
module pgnf_port_monitor #(
  parameter int NPINS = 8 // pins watched
) (
  input wire logic                        clk,               // system clock
  input wire logic                        sys_rst,           // sync reset
  input wire logic [pgnf_pkg::ADDR_W-1:0] reg_addr,          // register address
  input wire logic                        reg_rd,            // read strobe
  input wire logic [pgnf_pkg::DATA_W-1:0] reg_rdata,         // read data
  input wire logic [NPINS-1:0]            pin_in,            // pin levels
  input wire logic [NPINS-1:0]            pin_out,           // drive value
  input wire logic [NPINS-1:0]            pin_oe,            // drive enable
  input wire logic                        busa_clock_line,   // bus-A clock
  input wire logic                        busb_clock_line,   // bus-B clock
  input wire logic                        chan2_clock_line,  // ch2 clock
  input wire logic [NPINS-1:0]            irq_source_sel,    // source select
  input wire logic [NPINS-1:0]            irq_enable,        // irq enable
  input wire logic [NPINS-1:0]            ext_interrupt,     // active low irqs
  input wire logic [1:0]                  timer_x_clear_sel, // x clear select
  input wire logic [2:0]                  timer_x_clock_sel, // x clock select
  input wire logic [1:0]                  timer_y_clear_sel, // y clear select
  input wire logic [2:0]                  timer_y_clock_sel, // y clock select
  input wire logic                        timer_x_clear_in,  // x clear input
  input wire logic                        timer_x_clock_in,  // x clock input
  input wire logic                        timer_y_clear_in,  // y clear input
  input wire logic                        timer_y_clock_in   // y clock input
);
  // one clock domain, so one default clock and reset for all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_dir_reset: assert property ($past(sys_rst) |-> pin_oe == '0)
    else $error("pin driven right after reset");
  a_period_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == pgnf_pkg::OFS_PERIOD
    |-> reg_rdata[7:3] == 5'h00) else $error("period reserved bits not zero");
  a_irq_masked: assert property ((ext_interrupt | (irq_source_sel & irq_enable)) == '1)
    else $error("interrupt active while not selected");
  // a pin held still long enough must be seen through the synchronizer
  a_irq_follow: assert property ((irq_source_sel[2] && irq_enable[2]
    && $stable(pin_in[2]))[*6] |-> ext_interrupt[2] == pin_in[2]) else $error("irq lags pin");
  a_tmrx_clr_off: assert property (timer_x_clear_sel != 2'h3 |-> !timer_x_clear_in)
    else $error("timer x clear without select");
  a_tmrx_clk_off: assert property (timer_x_clock_sel < pgnf_pkg::CKS_EXT_LO
    |-> !timer_x_clock_in) else $error("timer x clock without select");
  a_tmry_inputs_off: assert property (!((timer_y_clear_sel != 2'h3 && timer_y_clear_in)
    || (timer_y_clock_sel < pgnf_pkg::CKS_EXT_LO && timer_y_clock_in)))
    else $error("timer y input without select");
  a_tmrx_follow: assert property ((timer_x_clear_sel == 2'h3
    && $stable(pin_in[0]))[*6] |-> timer_x_clear_in == pin_in[0]) else $error("clear lags pin");
  // a pin pushed high cannot be an open-drain line, so its pair is idle
  a_busa_idle: assert property (pin_oe[5] && pin_out[5] |-> busa_clock_line)
    else $error("bus-A clock low on general pin");
  a_busb_idle: assert property (pin_oe[7] && pin_out[7] |-> busb_clock_line)
    else $error("bus-B clock low on general pin");
  a_ch2_idle: assert property (pin_oe[3] && pin_out[3] |-> chan2_clock_line)
    else $error("ch2 clock low on general pin");
endmodule
bind pgnf_port pgnf_port_monitor #(.NPINS(NPINS)) u_monitor (.*);
`default_nettype wire

// ==== verif/tb_port_g_pin_mux_noise_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_port_g_pin_mux_noise_filter;
  logic       clk, sys_rst, reg_wr, reg_rd, drv_c, drv_d; // clock, strobes, i2c pulls
  logic [pgnf_pkg::ADDR_W-1:0] reg_addr;                    // register address
  logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe; // bus and pins
  logic [7:0] ext_val, ext_drv, irq_source_sel, irq_enable, ext_interrupt; // stimulus
  logic [1:0] timer_x_clear_sel, timer_y_clear_sel;         // timer clear selects
  logic [2:0] timer_x_clock_sel, timer_y_clock_sel;         // timer clock selects
  logic       busa_clock_line, busa_data_line, busb_clock_line, busb_data_line;
  logic       chan2_clock_line, chan2_data_line;            // i2c line levels
  logic       timer_x_clear_in, timer_x_clock_in, timer_y_clear_in, timer_y_clock_in;
  wire        busa_clock_drv_low = drv_c, busb_clock_drv_low = drv_c; // clock pulls
  wire        chan2_clock_drv_low = drv_c, busa_data_drv_low = drv_d; // mixed pulls
  wire        busb_data_drv_low = drv_d, chan2_data_drv_low = drv_d;  // data pulls
  logic [7:0] m, ln, v;                                     // masks, expected lines
  int         k, p, miscompares, tests_run;                 // loops and counters
  pgnf_port u_dut (.*);
  pgnf_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
                         .ext_drv(ext_drv), .pin_in(pin_in));
  // free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe; take it at the edge ending it
  task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    chk(nm, reg_rdata, exp);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial begin
    tk(100000);
    miscompares++;
    give_verdict();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, drv_c, drv_d} = {3'b100, 12'h000, 2'b00};
    {ext_val, ext_drv, irq_source_sel, irq_enable} = 32'h0;
    {timer_x_clear_sel, timer_y_clear_sel, timer_x_clock_sel, timer_y_clock_sel} = 10'h000;
    miscompares = 0;
    tests_run = 0;
    tk(20);
    sys_rst <= 1'b0;
    chk("oe_reset", pin_oe, 8'h00);
    for (k = 1; k < 16; k++) rdc("reg_reset", k[3:0], 8'h00);
    // every period code; software keeps the reserved bits zero, and they read zero
    for (k = 0; k < 8; k++) begin
      wr(pgnf_pkg::OFS_PERIOD, {5'h00, k[2:0]});
      rdc("period", pgnf_pkg::OFS_PERIOD, {5'h00, k[2:0]});
    end
    wr(pgnf_pkg::OFS_PERIOD, 8'h00);
    wr(pgnf_pkg::OFS_DIR_PIN, 8'hFF);
    wr(pgnf_pkg::OFS_OUTDATA, 8'hA5);
    tk(6);
    chk("oe_out", pin_oe, 8'hFF);
    chk("out_pp", pin_out, 8'hA5);
    rdc("pin_state", pgnf_pkg::OFS_DIR_PIN, 8'hA5);
    wr(pgnf_pkg::OFS_OUTDATA, 8'hFF);
    // each route bit and the ch2 enable, with clock or data pulled low
    for (k = 0; k < 5; k++) for (p = 0; p < 2; p++) begin
      drv_c <= (p == 0);
      drv_d <= (p == 1);
      wr(pgnf_pkg::OFS_ROUTE, k < 4 ? 8'h01 << k : 8'h00);
      wr(pgnf_pkg::OFS_I2C2, k == 4 ? 8'h80 : 8'h00);
      tk(6);
      m = k < 2 ? 8'h30 : k < 4 ? 8'hC0 : 8'h0C;
      ln = 8'h3F;
      ln[(k < 2 ? 2 : k < 4 ? 4 : 0) +: 2] = p ? 2'b10 : 2'b01;
      chk("route_oe", pin_oe, ~m | (m & (p ? 8'h54 : 8'hA8)));
      chk("route_out", pin_out, ~m);
      chk("lines", {2'b00, busb_clock_line, busb_data_line, busa_clock_line, busa_data_line,
                    chan2_clock_line, chan2_data_line}, ln);
    end
    wr(pgnf_pkg::OFS_I2C2, 8'h00);
    wr(pgnf_pkg::OFS_DIR_PIN, 8'h00);
    {ext_drv, irq_source_sel, irq_enable} <= 24'hFF0F3C;
    {timer_x_clear_sel, timer_x_clock_sel, timer_y_clear_sel, timer_y_clock_sel} <= 10'h3B7;
    // alternate inputs follow the pin while the port stays input
    for (p = 0; p < 2; p++) begin
      v = p ? 8'hFF : 8'h00;
      ext_val <= v;
      tk(6);
      chk("ext_irq", ext_interrupt, p ? 8'hFF : 8'hF3);
      chk("timer_in", {4'h0, timer_x_clear_in, timer_x_clock_in, timer_y_clear_in,
                       timer_y_clock_in}, p ? 8'h0D : 8'h00);
      chk("alt_oe", pin_oe, 8'h00);
      rdc("alt_state", pgnf_pkg::OFS_DIR_PIN, v);
    end
    // filter at the fastest tick: fall on a low, rise on a high expected level
    wr(pgnf_pkg::OFS_NCE, 8'hFF);
    ext_val <= 8'h00;
    tk(12);
    rdc("filt_fall", pgnf_pkg::OFS_DIR_PIN, 8'h00);
    wr(pgnf_pkg::OFS_NCMC, 8'hFF);
    ext_val <= 8'hFF;
    tk(12);
    rdc("filt_rise", pgnf_pkg::OFS_DIR_PIN, 8'hFF);
    wr(pgnf_pkg::OFS_NCMC, 8'h0F);
    ext_val <= 8'h00;
    tk(12);
    rdc("filt_hold", pgnf_pkg::OFS_DIR_PIN, 8'h0F);
    // slower ticks: nothing may move before the restarted divider comes round
    wr(pgnf_pkg::OFS_PERIOD, 8'h01);
    wr(pgnf_pkg::OFS_NCMC, 8'hFF);
    ext_val <= 8'hFF;
    tk(16);
    rdc("div32_early", pgnf_pkg::OFS_DIR_PIN, 8'h0F);
    tk(80);
    rdc("div32_late", pgnf_pkg::OFS_DIR_PIN, 8'hFF);
    wr(pgnf_pkg::OFS_PERIOD, 8'h02);
    wr(pgnf_pkg::OFS_NCMC, 8'h00);
    ext_val <= 8'h00;
    tk(4000);
    rdc("div8k_early", pgnf_pkg::OFS_DIR_PIN, 8'hFF);
    tk(14000);
    rdc("div8k_late", pgnf_pkg::OFS_DIR_PIN, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
